/* File: bench/pbseq_button_model.sv */
// Pushbutton contact and host alert line model
`timescale 1ns/100ps
module pbseq_button_model (
  input wire logic hclk,
  input wire logic press,
  input wire logic host_alert_out_n,
  input wire logic host_alert_oe_n,
  output logic push_switch_n,
  output logic alert_line
);
  logic last;
  logic [2:0] chatter;

  initial begin
    push_switch_n = 1'b1;
    last = 1'b0;
    chatter = 3'h0;
  end

  // Contacts chatter for about five cycles after every change, then the pin settles to the inverse of press
  always @(posedge hclk) begin
    if (press !== last) begin
      last <= press;
      chatter <= 3'h5;
    end else if (chatter != 3'h0) begin
      chatter <= chatter - 3'h1;
    end
    push_switch_n <= (chatter != 3'h0) ? ~push_switch_n : ~last;
  end

  // Host side pull-up holds the line high while the pin floats
  assign alert_line = host_alert_oe_n ? 1'b1 : host_alert_out_n;
endmodule : pbseq_button_model

/* File: bench/pbseq_checker.sv */
// Port assertions for the pushbutton sequencer
`timescale 1ns/100ps
`include "pbseq_defs.svh"
module pbseq_checker #(
  parameter logic [31:0] SHUTDOWN_CYC = 32'h0000_0014
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push_switch_n,
  input wire logic mode_select_a,
  input wire logic adapter_monitor,
  input wire logic primary_path_drive,
  input wire logic secondary_path_drive,
  input wire logic converter_run,
  input wire logic host_alert_out_n,
  input wire logic host_alert_oe_n,
  input wire logic hreadyout,
  input wire logic hresp
);
  logic armed;
  logic [31:0] run_cnt;
  logic [31:0] low_cnt;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Times the shutdown that follows an adapter drop while powered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed <= 1'b0;
      run_cnt <= 32'h0000_0000;
    end else if (mode_select_a && $fell(adapter_monitor) && converter_run) begin
      armed <= 1'b1;
      run_cnt <= 32'h0000_0000;
    end else if (armed) begin
      run_cnt <= run_cnt + 32'h0000_0001;
      if (!converter_run) begin
        armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= 32'h0000_0000;
    end else if (push_switch_n) begin
      low_cnt <= 32'h0000_0000;
    end else if (low_cnt != 32'hFFFF_FFFF) begin
      low_cnt <= low_cnt + 32'h0000_0001;
    end
  end

  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  alert_level_a: assert property (!host_alert_out_n) else $error("alert drive value not low");
  drives_off_a: assert property ($fell(converter_run) |-> !primary_path_drive && !secondary_path_drive)
    else $error("path drive left on after run dropped");
  drives_up_a: assert property ($rose(converter_run) && mode_select_a |-> primary_path_drive && secondary_path_drive)
    else $error("path drives not enabled with run");
  adapter_rise_a: assert property (mode_select_a && $past(mode_select_a, 4) && $rose(adapter_monitor)
    |-> ##[1:8] converter_run) else $error("adapter rise did not power up");
  shut_min_a: assert property (armed && !converter_run |-> run_cnt >= SHUTDOWN_CYC)
    else $error("shutdown shorter than set");
  shut_max_a: assert property (armed |-> run_cnt <= SHUTDOWN_CYC + 32'h0000_0008)
    else $error("shutdown started late or ran long");
  alert_qual_a: assert property ($fell(host_alert_oe_n) && !push_switch_n
    |-> low_cnt >= `PBSEQ_FIXED_DEB_CYC) else $error("alert before fixed push time");
endmodule : pbseq_checker

bind pbseq_top pbseq_checker #(.SHUTDOWN_CYC(SHUTDOWN_CYC)) pbseq_checker_i (.hclk(hclk), .hresetn(hresetn),
  .push_switch_n(push_switch_n), .mode_select_a(mode_select_a), .adapter_monitor(adapter_monitor),
  .primary_path_drive(primary_path_drive), .secondary_path_drive(secondary_path_drive),
  .converter_run(converter_run), .host_alert_out_n(host_alert_out_n), .host_alert_oe_n(host_alert_oe_n),
  .hreadyout(hreadyout), .hresp(hresp));

/* File: bench/testbench.sv */
// Self-checking bench for the pushbutton sequencer
`timescale 1ns/100ps
`include "pbseq_defs.svh"
module testbench;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic press = 1'b0;
  logic push_switch_n;
  logic mode_select_a = 1'b0;
  logic adapter_monitor = 1'b0;
  logic primary_path_drive;
  logic secondary_path_drive;
  logic converter_run;
  logic host_alert_out_n;
  logic host_alert_oe_n;
  logic irq;
  logic alert_line;
  logic [31:0] rd;
  int err_count = 0;
  int tests_run = 0;
  int n;

  always #10 hclk = ~hclk;

  // Short shutdown keeps the run brief
  pbseq_top #(.SHUTDOWN_CYC(32'h0000_0014)) pbseq_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .push_switch_n(push_switch_n),
    .mode_select_a(mode_select_a), .adapter_monitor(adapter_monitor), .primary_path_drive(primary_path_drive),
    .secondary_path_drive(secondary_path_drive), .converter_run(converter_run),
    .host_alert_out_n(host_alert_out_n), .host_alert_oe_n(host_alert_oe_n), .irq(irq));

  pbseq_button_model pbseq_button_model_i (.hclk(hclk), .press(press), .host_alert_out_n(host_alert_out_n),
    .host_alert_oe_n(host_alert_oe_n), .push_switch_n(push_switch_n), .alert_line(alert_line));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask : cyc

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wait_run(input logic v);
    n = 0;
    while (converter_run !== v && n < 100) begin
      cyc(1);
      n++;
    end
  endtask : wait_run

  task automatic t_reset;
    chk({28'h000_0000, primary_path_drive, secondary_path_drive, converter_run, irq}, ZERO);
    chk({31'h0000_0000, alert_line}, ONE);
    bus(1'b0, `PBSEQ_ADDR_STATUS, ZERO);
    chk(rd, 32'h0000_0010);
    bus(1'b0, `PBSEQ_ADDR_IRQ_MASK, ZERO);
    chk(rd, ZERO);
    bus(1'b0, 12'h020, ZERO);
    chk(rd, ZERO);
    bus(1'b1, `PBSEQ_ADDR_OFF_EXTRA, 32'h0000_0005);
    bus(1'b0, `PBSEQ_ADDR_OFF_EXTRA, ZERO);
    chk(rd, 32'h0000_0005);
    $display("reset test done");
  endtask : t_reset

  task automatic t_power_up;
    @(posedge hclk);
    adapter_monitor <= 1'b1;
    cyc(10);
    chk({31'h0000_0000, converter_run}, ZERO);
    @(posedge hclk);
    adapter_monitor <= 1'b0;
    cyc(4);
    @(posedge hclk);
    mode_select_a <= 1'b1;
    cyc(4);
    @(posedge hclk);
    adapter_monitor <= 1'b1;
    wait_run(1'b1);
    chk(32'(n <= 8), ONE);
    chk({30'h0000_0000, primary_path_drive, secondary_path_drive}, 32'h0000_0003);
    bus(1'b0, `PBSEQ_ADDR_STATUS, ZERO);
    chk(rd & ONE, ONE);
    bus(1'b0, `PBSEQ_ADDR_IRQ_STAT, ZERO);
    chk(rd & ONE, ONE);
    cyc(2);
    chk({31'h0000_0000, irq}, ZERO);
    bus(1'b1, `PBSEQ_ADDR_IRQ_MASK, ONE);
    cyc(2);
    chk({31'h0000_0000, irq}, ONE);
    bus(1'b1, `PBSEQ_ADDR_IRQ_STAT, ONE);
    cyc(2);
    chk({31'h0000_0000, irq}, ZERO);
    bus(1'b0, `PBSEQ_ADDR_IRQ_STAT, ZERO);
    chk(rd & ONE, ZERO);
    $display("power-up test done");
  endtask : t_power_up

  task automatic t_short_push;
    @(posedge hclk);
    press <= 1'b1;
    cyc(400);
    chk({31'h0000_0000, alert_line}, ONE);
    @(posedge hclk);
    press <= 1'b0;
    cyc(100);
    chk({31'h0000_0000, alert_line}, ONE);
    chk({31'h0000_0000, converter_run}, ONE);
    $display("short push test done");
  endtask : t_short_push

  task automatic t_power_down;
    @(posedge hclk);
    adapter_monitor <= 1'b0;
    cyc(10);
    chk({31'h0000_0000, alert_line}, ZERO);
    wait_run(1'b0);
    chk(32'(n + 10 >= 19 && n + 10 <= 30), ONE);
    chk({30'h0000_0000, primary_path_drive, secondary_path_drive}, ZERO);
    bus(1'b0, `PBSEQ_ADDR_IRQ_STAT, ZERO);
    chk(rd & 32'h0000_0008, 32'h0000_0008);
    bus(1'b0, `PBSEQ_ADDR_STATUS, ZERO);
    chk(rd & ONE, ZERO);
    chk({31'h0000_0000, alert_line}, ONE);
    $display("power-down test done");
  endtask : t_power_down

  task automatic t_recycle;
    @(posedge hclk);
    adapter_monitor <= 1'b1;
    wait_run(1'b1);
    chk({31'h0000_0000, converter_run}, ONE);
    bus(1'b1, `PBSEQ_ADDR_CTRL, ONE);
    wait_run(1'b0);
    chk({31'h0000_0000, converter_run}, ZERO);
    @(posedge hclk);
    adapter_monitor <= 1'b0;
    cyc(6);
    @(posedge hclk);
    adapter_monitor <= 1'b1;
    wait_run(1'b1);
    chk({31'h0000_0000, converter_run}, ONE);
    bus(1'b1, `PBSEQ_ADDR_CTRL, ONE);
    wait_run(1'b0);
    bus(1'b1, `PBSEQ_ADDR_CTRL, 32'h0000_0002);
    wait_run(1'b1);
    bus(1'b0, `PBSEQ_ADDR_STATUS, ZERO);
    chk(rd & 32'h0000_0009, 32'h0000_0009);
    $display("recycle test done");
  endtask : t_recycle

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_power_up();
    t_short_push();
    t_power_down();
    t_recycle();
    summarize();
  end

  // Whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    summarize();
  end
endmodule : testbench

/* File: src/pbseq_cmd_if.sv */
// Command and status carrier between the debouncer and the sequencer
`timescale 1ns/100ps
interface pbseq_cmd_if;
  logic system_on;
  logic on_press;
  logic off_press;
  logic alert_hold;
  logic alert_drop;

  modport deb (
    input system_on,
    output on_press,
    output off_press,
    output alert_hold,
    output alert_drop
  );
  modport seq (
    output system_on,
    input on_press,
    input off_press,
    input alert_hold,
    input alert_drop
  );
endinterface : pbseq_cmd_if

/* File: src/pbseq_debounce.sv */
// Pushbutton debouncer: fixed and programmable push times, fixed release time
`timescale 1ns/100ps
`include "pbseq_defs.svh"
module pbseq_debounce (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push_n,
  input wire logic [31:0] on_extra,
  input wire logic [31:0] off_extra,
  pbseq_cmd_if.deb cmd
);
  localparam logic [31:0] FIXED_CYC = 32'(`PBSEQ_FIXED_DEB_CYC);

  pbseq_pkg::pbseq_deb_t state;
  logic [31:0] count;
  logic off_push;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= pbseq_pkg::PBSEQ_IDLE;
      count <= 32'h0000_0000;
      off_push <= 1'b0;
      cmd.on_press <= 1'b0;
      cmd.off_press <= 1'b0;
      cmd.alert_hold <= 1'b0;
      cmd.alert_drop <= 1'b0;
    end else begin
      cmd.on_press <= 1'b0;
      cmd.off_press <= 1'b0;
      cmd.alert_drop <= 1'b0;
      case (state)
        pbseq_pkg::PBSEQ_IDLE: begin
          count <= 32'h0000_0000;
          if (!push_n) begin
            state <= pbseq_pkg::PBSEQ_FIXED;
            off_push <= cmd.system_on;
          end
        end
        pbseq_pkg::PBSEQ_FIXED: begin
          if (push_n) begin
            state <= pbseq_pkg::PBSEQ_IDLE;
          end else if (count + 32'h0000_0001 >= FIXED_CYC) begin
            count <= 32'h0000_0000;
            state <= pbseq_pkg::PBSEQ_EXTRA;
            cmd.alert_hold <= off_push;
          end else begin
            count <= count + 32'h0000_0001;
          end
        end
        pbseq_pkg::PBSEQ_EXTRA: begin
          if (push_n) begin
            state <= pbseq_pkg::PBSEQ_IDLE;
            cmd.alert_hold <= 1'b0;
            cmd.alert_drop <= off_push;
          end else if (count >= (off_push ? off_extra : on_extra)) begin
            state <= pbseq_pkg::PBSEQ_HELD;
            cmd.on_press <= !off_push;
            cmd.off_press <= off_push;
            cmd.alert_hold <= 1'b0;
          end else begin
            count <= count + 32'h0000_0001;
          end
        end
        pbseq_pkg::PBSEQ_HELD: begin
          count <= 32'h0000_0000;
          if (push_n) begin
            state <= pbseq_pkg::PBSEQ_RELEASE;
          end
        end
        pbseq_pkg::PBSEQ_RELEASE: begin
          if (!push_n) begin
            count <= 32'h0000_0000;
            state <= pbseq_pkg::PBSEQ_HELD;
          end else if (count + 32'h0000_0001 >= FIXED_CYC) begin
            state <= pbseq_pkg::PBSEQ_IDLE;
          end else begin
            count <= count + 32'h0000_0001;
          end
        end
        default: begin
          state <= pbseq_pkg::PBSEQ_IDLE;
        end
      endcase
    end
  end
endmodule : pbseq_debounce

/* File: src/pbseq_defs.svh */
// Offsets, field positions, reset values and timing counts of the pushbutton sequencer
`ifndef PBSEQ_DEFS_SVH
`define PBSEQ_DEFS_SVH

`define PBSEQ_CLK_HZ 50000000
`define PBSEQ_FIXED_DEB_MS 26
`define PBSEQ_FIXED_DEB_CYC ((`PBSEQ_CLK_HZ / 1000) * `PBSEQ_FIXED_DEB_MS)
`define PBSEQ_SHUTDOWN_US 100000
`define PBSEQ_SHUTDOWN_CYC ((`PBSEQ_CLK_HZ / 1000000) * `PBSEQ_SHUTDOWN_US)
`define PBSEQ_ON_EXTRA_CYC 32'h0000_0000
`define PBSEQ_OFF_EXTRA_CYC 32'h0000_0000

`define PBSEQ_ADDR_CTRL 12'h000
`define PBSEQ_ADDR_STATUS 12'h004
`define PBSEQ_ADDR_IRQ_STAT 12'h008
`define PBSEQ_ADDR_IRQ_MASK 12'h00C
`define PBSEQ_ADDR_ON_EXTRA 12'h010
`define PBSEQ_ADDR_OFF_EXTRA 12'h014

`define PBSEQ_CTRL_SW_OFF 0
`define PBSEQ_CTRL_SW_ON 1

`define PBSEQ_ST_ON_OFF 0
`define PBSEQ_ST_PRIMARY 1
`define PBSEQ_ST_SECONDARY 2
`define PBSEQ_ST_RUN 3
`define PBSEQ_ST_ALERT_N 4
`define PBSEQ_ST_SHUTDOWN 5
`define PBSEQ_ST_MODE_A 6
`define PBSEQ_ST_ADAPTER 7

`define PBSEQ_IRQ_ON_CMD 0
`define PBSEQ_IRQ_OFF_CMD 1
`define PBSEQ_IRQ_ALERT 2
`define PBSEQ_IRQ_PWR_DOWN 3
`define PBSEQ_IRQ_BITS 4
`define PBSEQ_IRQ_MASK_RESET 4'h0

`endif

/* File: src/pbseq_pkg.sv */
// Types of the pushbutton sequencer
package pbseq_pkg;
  typedef enum logic [4:0] {
    PBSEQ_IDLE = 5'h01,
    PBSEQ_FIXED = 5'h02,
    PBSEQ_EXTRA = 5'h04,
    PBSEQ_HELD = 5'h08,
    PBSEQ_RELEASE = 5'h10
  } pbseq_deb_t;

  typedef enum logic [2:0] {
    PBSEQ_OFF = 3'h1,
    PBSEQ_ON = 3'h2,
    PBSEQ_SHUT = 3'h4
  } pbseq_pwr_t;
endpackage : pbseq_pkg

/* File: src/pbseq_sync.sv */
// Two-flop synchroniser for a group of comparator outputs
`timescale 1ns/100ps
module pbseq_sync #(
  parameter int WIDTH = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule : pbseq_sync

/* File: src/pbseq_top.sv */
// Pushbutton power sequencer with AHB-Lite register slave and interrupt
// Contract
// - With mode_select_a high, adapter_monitor rising is an on command and falling is an off command.
// - In that mode, adapter_monitor rising enables both path drivers and the converter run output.
// - In that mode, adapter_monitor falling starts the shutdown sequence at once.
// - When shutdown ends, both path drivers and the converter run output are switched off.
// - In that mode, a valid pushbutton off also powers down through the normal shutdown.
// - After a pushbutton power-off, power returns on a valid press or an adapter fall-then-rise.
// - Debounced pushbutton events set the on/off state and each change starts a power sequence.
// - The on/off state is high after an accepted turn-on and low after an accepted turn-off.
// - A push must stay low for a fixed 26ms before it can count.
// - After that a push must stay low for a further programmable on or off time.
// - During a push while on, the alert output goes low once the fixed 26ms has passed.
// - If the button is released before the off time ends, the alert is released at once and no shutdown follows.
// - If the button is still low at the end of the off time, the alert stays low through shutdown.
// - After a valid push, a release counts only after 26ms of uninterrupted high.
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`include "pbseq_defs.svh"
module pbseq_top #(
  parameter logic [31:0] SHUTDOWN_CYC = 32'(`PBSEQ_SHUTDOWN_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic push_switch_n,
  input wire logic mode_select_a,
  input wire logic adapter_monitor,
  output logic primary_path_drive,
  output logic secondary_path_drive,
  output logic converter_run,
  output logic host_alert_out_n,
  output logic host_alert_oe_n,
  output logic irq
);
  logic [2:0] sync_q;
  logic push_n;
  logic mode_a;
  logic adapter;
  logic adapter_d;
  logic adapter_rise;
  logic adapter_fall;
  logic [31:0] on_extra;
  logic [31:0] off_extra;
  logic [1:0] sw_cmd;
  logic [`PBSEQ_IRQ_BITS-1:0] irq_stat;
  logic [`PBSEQ_IRQ_BITS-1:0] irq_mask;
  logic [`PBSEQ_IRQ_BITS-1:0] irq_event;
  logic on_off;
  logic [31:0] shut_count;
  logic shut_alert;
  logic alert_n;
  pbseq_pkg::pbseq_pwr_t pwr;
  logic ph_valid;
  logic ph_write;
  logic [11:0] ph_addr;
  logic [31:0] rd_mux;
  logic [7:0] status_word;
  logic turn_on;
  logic turn_off;
  logic adapter_on;
  logic adapter_off;
  logic shut_last;
  logic next_drive;

  pbseq_cmd_if cmd ();

  pbseq_sync #(
    .WIDTH(3)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({~push_switch_n, mode_select_a, adapter_monitor}),
    .sync_out(sync_q)
  );

  // Button rides inverted so the cleared flops read as released after reset
  assign push_n = !sync_q[2];
  assign mode_a = sync_q[1];
  assign adapter = sync_q[0];
  assign adapter_rise = adapter && !adapter_d;
  assign adapter_fall = !adapter && adapter_d;

  pbseq_debounce u_deb (
    .hclk(hclk),
    .hresetn(hresetn),
    .push_n(push_n),
    .on_extra(on_extra),
    .off_extra(off_extra),
    .cmd(cmd.deb)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adapter_d <= 1'b0;
    end else begin
      adapter_d <= adapter;
    end
  end

  // Adapter edges only count as commands with mode A high
  assign adapter_on = mode_a && adapter_rise;
  assign adapter_off = mode_a && adapter_fall;
  assign turn_on = cmd.on_press || sw_cmd[`PBSEQ_CTRL_SW_ON] || adapter_on;
  assign turn_off = cmd.off_press || sw_cmd[`PBSEQ_CTRL_SW_OFF] || adapter_off;

  // Last accepted command; off wins a same-cycle tie so a collapsing adapter is never ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_off <= 1'b0;
    end else if (turn_off) begin
      on_off <= 1'b0;
    end else if (turn_on) begin
      on_off <= 1'b1;
    end
  end

  // Shutdown ends on the edge where the counter reaches its length
  assign shut_last = (pwr == pbseq_pkg::PBSEQ_SHUT) && (shut_count + 32'h0000_0001 >= SHUTDOWN_CYC);

  assign cmd.system_on = (pwr == pbseq_pkg::PBSEQ_ON);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr <= pbseq_pkg::PBSEQ_OFF;
      shut_count <= 32'h0000_0000;
      shut_alert <= 1'b0;
    end else begin
      case (pwr)
        pbseq_pkg::PBSEQ_OFF: begin
          shut_count <= 32'h0000_0000;
          shut_alert <= 1'b0;
          if (on_off) begin
            pwr <= pbseq_pkg::PBSEQ_ON;
          end
        end
        pbseq_pkg::PBSEQ_ON: begin
          if (!on_off) begin
            pwr <= pbseq_pkg::PBSEQ_SHUT;
            shut_count <= 32'h0000_0000;
            shut_alert <= 1'b1;
          end
        end
        pbseq_pkg::PBSEQ_SHUT: begin
          if (shut_last) begin
            pwr <= pbseq_pkg::PBSEQ_OFF;
          end else begin
            shut_count <= shut_count + 32'h0000_0001;
          end
        end
        default: begin
          pwr <= pbseq_pkg::PBSEQ_OFF;
        end
      endcase
    end
  end

  // Alert low while an off push qualifies, while an accepted off waits and through shutdown
  always_comb begin
    alert_n = 1'b1;
    if (cmd.alert_hold) begin
      alert_n = 1'b0;
    end else if (cmd.off_press && !cmd.alert_drop) begin
      alert_n = 1'b0;
    end else if (pwr == pbseq_pkg::PBSEQ_ON && !on_off) begin
      // Bridges the cycle between the accepted off and the start of shutdown
      alert_n = 1'b0;
    end else if (shut_alert) begin
      alert_n = 1'b0;
    end
  end

  // Drives stay on through shutdown so the host can finish its housekeeping
  always_comb begin
    next_drive = 1'b0;
    case (pwr)
      pbseq_pkg::PBSEQ_OFF: begin
        next_drive = 1'b0;
      end
      pbseq_pkg::PBSEQ_ON: begin
        next_drive = 1'b1;
      end
      pbseq_pkg::PBSEQ_SHUT: begin
        next_drive = !shut_last;
      end
      default: begin
        next_drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_path_drive <= 1'b0;
      secondary_path_drive <= 1'b0;
      converter_run <= 1'b0;
    end else begin
      primary_path_drive <= next_drive;
      secondary_path_drive <= next_drive;
      converter_run <= next_drive;
    end
  end

  // Open drain: only ever pulls low, released means high impedance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_alert_out_n <= 1'b0;
      host_alert_oe_n <= 1'b1;
    end else begin
      host_alert_out_n <= 1'b0;
      host_alert_oe_n <= alert_n;
    end
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 12'h000;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_extra <= `PBSEQ_ON_EXTRA_CYC;
      off_extra <= `PBSEQ_OFF_EXTRA_CYC;
      irq_mask <= `PBSEQ_IRQ_MASK_RESET;
      sw_cmd <= 2'h0;
    end else begin
      sw_cmd <= 2'h0;
      if (ph_valid && ph_write) begin
        case (ph_addr)
          `PBSEQ_ADDR_CTRL: begin
            sw_cmd <= hwdata[1:0];
          end
          `PBSEQ_ADDR_IRQ_MASK: begin
            irq_mask <= hwdata[`PBSEQ_IRQ_BITS-1:0];
          end
          `PBSEQ_ADDR_ON_EXTRA: begin
            on_extra <= hwdata;
          end
          `PBSEQ_ADDR_OFF_EXTRA: begin
            off_extra <= hwdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[`PBSEQ_IRQ_ON_CMD] = turn_on;
    irq_event[`PBSEQ_IRQ_OFF_CMD] = turn_off;
    irq_event[`PBSEQ_IRQ_ALERT] = cmd.alert_hold && !shut_alert;
    irq_event[`PBSEQ_IRQ_PWR_DOWN] = shut_last;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
    end else if (ph_valid && ph_write && ph_addr == `PBSEQ_ADDR_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~hwdata[`PBSEQ_IRQ_BITS-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  always_comb begin
    status_word = 8'h00;
    status_word[`PBSEQ_ST_ON_OFF] = on_off;
    status_word[`PBSEQ_ST_PRIMARY] = primary_path_drive;
    status_word[`PBSEQ_ST_SECONDARY] = secondary_path_drive;
    status_word[`PBSEQ_ST_RUN] = converter_run;
    status_word[`PBSEQ_ST_ALERT_N] = host_alert_oe_n;
    status_word[`PBSEQ_ST_SHUTDOWN] = (pwr == pbseq_pkg::PBSEQ_SHUT);
    status_word[`PBSEQ_ST_MODE_A] = mode_a;
    status_word[`PBSEQ_ST_ADAPTER] = adapter;
  end

  always_comb begin
    case (haddr[11:0])
      `PBSEQ_ADDR_STATUS: begin
        rd_mux = {24'h00_0000, status_word};
      end
      `PBSEQ_ADDR_IRQ_STAT: begin
        rd_mux = {28'h000_0000, irq_stat};
      end
      `PBSEQ_ADDR_IRQ_MASK: begin
        rd_mux = {28'h000_0000, irq_mask};
      end
      `PBSEQ_ADDR_ON_EXTRA: begin
        rd_mux = on_extra;
      end
      `PBSEQ_ADDR_OFF_EXTRA: begin
        rd_mux = off_extra;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered at address phase so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end
endmodule : pbseq_top
